// ---- verilog/tdl_defines.svh ----
`ifndef TDL_DEFINES_SVH
`define TDL_DEFINES_SVH

// Register offsets on the configuration port
`define TDL_ADDR_W             7
`define TDL_ADDR_DEV           7'h0E
`define TDL_ADDR_LOCK          7'h15
`define TDL_ADDR_ANALOG        7'h17
`define TDL_ADDR_SWING         7'h18

// Reset values
`define TDL_RST_DEV            8'hE8
`define TDL_RST_LOCK           8'h00
`define TDL_RST_ANALOG         8'h83
`define TDL_RST_SWING          8'hC1

// Readable bits; reserved bits read as zero
`define TDL_MASK_DEV           8'hFF
`define TDL_MASK_LOCK          8'hFF
`define TDL_MASK_ANALOG        8'h9F
`define TDL_MASK_SWING         8'hC7

// Deviation exponent offsets per band
`define TDL_DEV_OFS_LOW        5'h10
`define TDL_DEV_OFS_HIGH       5'h0F

// Lock pin selector codes
`define TDL_SEL_LOW            4'h0
`define TDL_SEL_HIGH           4'h1
`define TDL_SEL_STEADY         4'h2
`define TDL_SEL_MOMENT         4'h3
`define TDL_SEL_CALDONE        4'h5
`define TDL_SEL_XOSC           4'h7
`define TDL_SEL_REFCLK         4'h8
`define TDL_SEL_PRE            4'hB
`define TDL_SEL_SD             4'hC
`define TDL_SEL_MODEM          4'hD
`define TDL_SEL_CALCMP         4'hE
`define TDL_SEL_FCMP           4'hF

// Lock window widths in prescaler cycles
`define TDL_WIN_NARROW         3'h2
`define TDL_WIN_WIDE           3'h4

// Lock and out-of-lock counter thresholds per accuracy code
`define TDL_LOCK_THR0          10'h07F
`define TDL_LOCK_THR1          10'h0FF
`define TDL_LOCK_THR2          10'h1FF
`define TDL_LOCK_THR3          10'h3FF
`define TDL_UNLOCK_THR0        10'h06F
`define TDL_UNLOCK_THR1        10'h0EF
`define TDL_UNLOCK_THR2        10'h1EF
`define TDL_UNLOCK_THR3        10'h3EF

`endif

// ---- verilog/tdl_pkg.sv ----
package tdl_pkg;

	// Raw contents of the four configuration registers
	typedef struct packed {
		logic [7:0] dev;
		logic [7:0] lock;
		logic [7:0] analog;
		logic [7:0] swing;
	} tdl_regs_type;

	// Levels presented to the modulator
	typedef struct packed {
		logic              shaping_en;
		logic              ook_en;
		logic              high_band_sel;
		logic        [2:0] dev_exponent;
		logic        [3:0] dev_mantissa;
		logic signed [4:0] dev_pow2;
	} tdl_mod_ctrl_type;

	// Levels presented to the analog bias blocks
	typedef struct packed {
		logic       phase_det_long_delay;
		logic       pa_boost;
		logic [1:0] div_buff_current;
		logic [1:0] pre_swing;
		logic [2:0] tx_swing;
	} tdl_bias_ctrl_type;

	// Internal signals that may be routed to the lock pin
	typedef struct packed {
		logic crystal_osc_clk;
		logic ref_clk_lvl;
		logic prescaler_clk;
		logic sigma_delta_clk;
		logic modem_clk;
		logic osc_cal_comparator;
		logic freq_comparator;
		logic cal_complete;
	} tdl_pin_src_type;

	// Lock detector state
	typedef struct packed {
		logic [9:0] cnt;
		logic       lock_ind_steady;
		logic       lock_ind_momentary;
	} tdl_lock_state_type;

	// Top-level state
	typedef struct packed {
		tdl_regs_type      regs;
		tdl_mod_ctrl_type  mod;
		tdl_bias_ctrl_type bias;
		logic              lock_pin;
		logic              rd_valid;
		logic [7:0]        rd_data;
	} tdl_top_state_type;

endpackage : tdl_pkg

// ---- verilog/tdl_lock_detect.sv ----
`timescale 1ns/1ps
`include "tdl_defines.svh"

module tdl_lock_detect (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	// Phase comparison results
	input  wire logic       cmp_valid,
	input  wire logic [2:0] err_cycles,
	// Configuration levels
	input  wire logic       window_wide,
	input  wire logic       updown_mode,
	input  wire logic [1:0] accuracy,
	// Lock indications, active high here
	output logic            lock_ind_steady,
	output logic            lock_ind_momentary
);

	tdl_pkg::tdl_lock_state_type st_q;   // Registered state
	tdl_pkg::tdl_lock_state_type st_d;   // Next state
	logic [2:0]                  win;    // Window width in prescaler cycles
	logic [9:0]                  thr;    // Lock threshold
	logic [9:0]                  unl;    // Out-of-lock threshold
	logic                        hit;    // Comparison inside window

	// Next-state logic
	always_comb begin
		st_d = st_q;
		win  = window_wide ? `TDL_WIN_WIDE : `TDL_WIN_NARROW;
		case (accuracy)
			2'h0: begin
				thr = `TDL_LOCK_THR0;
				unl = `TDL_UNLOCK_THR0;
			end
			2'h1: begin
				thr = `TDL_LOCK_THR1;
				unl = `TDL_UNLOCK_THR1;
			end
			2'h2: begin
				thr = `TDL_LOCK_THR2;
				unl = `TDL_UNLOCK_THR2;
			end
			default: begin
				thr = `TDL_LOCK_THR3;
				unl = `TDL_UNLOCK_THR3;
			end
		endcase
		hit = err_cycles < win;
		if (cmp_valid) begin
			st_d.lock_ind_momentary = hit;
			if (hit) begin
				// Count up, saturating at the lock threshold
				st_d.cnt = (st_q.cnt >= thr) ? thr : st_q.cnt + 10'h001;
			end else if (updown_mode) begin
				// Up/down scheme: step down, floor at zero
				st_d.cnt = (st_q.cnt == 10'h000) ? 10'h000 : st_q.cnt - 10'h001;
			end else begin
				// Restart scheme: any miss clears the count
				st_d.cnt = 10'h000;
			end
			// Hysteresis between lock and out-of-lock levels
			if (st_d.cnt == thr) begin
				st_d.lock_ind_steady = 1'b1;
			end else if (st_d.cnt <= unl) begin
				st_d.lock_ind_steady = 1'b0;
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign lock_ind_steady    = st_q.lock_ind_steady;
	assign lock_ind_momentary = st_q.lock_ind_momentary;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	property p_window;
		cmp_valid && (err_cycles >= (window_wide ? 3'h4 : 3'h2)) |=> !lock_ind_momentary;
	endproperty
	a_window: assert property (p_window) else $error("Miss outside window not seen");

	property p_restart;
		cmp_valid && !updown_mode && !hit |=> st_q.cnt == 10'h000;
	endproperty
	a_restart: assert property (p_restart) else $error("Restart mode did not clear");

	property p_lock_thr;
		$rose(lock_ind_steady) |-> st_q.cnt == $past(thr);
	endproperty
	a_lock_thr: assert property (p_lock_thr) else $error("Lock declared off threshold");

endmodule : tdl_lock_detect

// ---- verilog/tdl_config_regs.sv ----
`timescale 1ns/1ps
`include "tdl_defines.svh"


module tdl_config_regs (
	// Clock and reset
	input  wire logic                           ref_clk,
	input  wire logic                           sys_rst,
	// Configuration register port
	input  wire logic                           cfg_wr_en,
	input  wire logic                           cfg_rd_en,
	input  wire logic [`TDL_ADDR_W-1:0]         cfg_addr,
	input  wire logic [7:0]                     cfg_wr_data,
	output logic [7:0]                          cfg_rd_data,
	output logic                                cfg_rd_valid,
	// Synthesizer phase comparison results
	input  wire logic                           pd_cmp_valid,
	input  wire logic [2:0]                     pd_err_cycles,
	// Signals that may be routed to the lock pin
	input  wire tdl_pkg::tdl_pin_src_type       pin_src,
	// Control levels
	output tdl_pkg::tdl_mod_ctrl_type           mod_ctrl,
	output tdl_pkg::tdl_bias_ctrl_type          bias_ctrl,
	output logic                                lock_pin
);

	tdl_pkg::tdl_top_state_type st_q;          // Registered state
	tdl_pkg::tdl_top_state_type st_d;          // Next state
	logic                       lock_ind_steady;    // From lock detector
	logic                       lock_ind_momentary; // From lock detector
	logic [3:0]                 pin_sel;       // Current selector code

	// Lock detector steered by the lock register
	tdl_lock_detect tdl_lock_detect_inst (
		.ref_clk            (ref_clk),
		.sys_rst            (sys_rst),
		.cmp_valid          (pd_cmp_valid),
		.err_cycles         (pd_err_cycles),
		.window_wide        (st_q.regs.lock[3]),
		.updown_mode        (st_q.regs.lock[2]),
		.accuracy           (st_q.regs.lock[1:0]),
		.lock_ind_steady    (lock_ind_steady),
		.lock_ind_momentary (lock_ind_momentary)
	);

	assign pin_sel = st_q.regs.lock[7:4];

	// Register writes, decoded control levels, pin mux and read port
	always_comb begin
		st_d          = st_q;
		st_d.rd_valid = 1'b0;
		// Writes update only the addressed register; others hold
		if (cfg_wr_en) begin
			case (cfg_addr)
				`TDL_ADDR_DEV:    st_d.regs.dev    = cfg_wr_data;
				`TDL_ADDR_LOCK:   st_d.regs.lock   = cfg_wr_data;
				`TDL_ADDR_ANALOG: st_d.regs.analog = cfg_wr_data & `TDL_MASK_ANALOG;
				`TDL_ADDR_SWING:  st_d.regs.swing  = cfg_wr_data & `TDL_MASK_SWING;
				default:          st_d.regs        = st_q.regs;
			endcase
		end
		// Modulator levels follow the register contents
		st_d.mod.shaping_en    = st_d.regs.dev[7];
		st_d.mod.dev_exponent  = st_d.regs.dev[6:4];
		st_d.mod.dev_mantissa  = st_d.regs.dev[3:0];
		st_d.mod.ook_en        = st_d.regs.dev[3:0] == 4'h0;
		st_d.mod.high_band_sel = st_d.regs.analog[7];
		// Power-of-two scale of the deviation, per band offset
		st_d.mod.dev_pow2 = $signed({2'b00, st_d.regs.dev[6:4]} -
			(st_d.regs.analog[7] ? `TDL_DEV_OFS_HIGH : `TDL_DEV_OFS_LOW));
		// Analog bias levels
		st_d.bias.phase_det_long_delay = st_d.regs.analog[4];
		st_d.bias.pa_boost             = st_d.regs.analog[2];
		st_d.bias.div_buff_current     = st_d.regs.analog[1:0];
		st_d.bias.pre_swing            = st_d.regs.swing[7:6];
		st_d.bias.tx_swing             = st_d.regs.swing[2:0];
		// Lock pin selection; unused codes drive low
		case (pin_sel)
			`TDL_SEL_HIGH:    st_d.lock_pin = 1'b1;
			`TDL_SEL_STEADY:  st_d.lock_pin = ~lock_ind_steady;
			`TDL_SEL_MOMENT:  st_d.lock_pin = ~lock_ind_momentary;
			`TDL_SEL_CALDONE: st_d.lock_pin = ~pin_src.cal_complete;
			`TDL_SEL_XOSC:    st_d.lock_pin = pin_src.crystal_osc_clk;
			`TDL_SEL_REFCLK:  st_d.lock_pin = pin_src.ref_clk_lvl;
			`TDL_SEL_PRE:     st_d.lock_pin = pin_src.prescaler_clk;
			`TDL_SEL_SD:      st_d.lock_pin = pin_src.sigma_delta_clk;
			`TDL_SEL_MODEM:   st_d.lock_pin = pin_src.modem_clk;
			`TDL_SEL_CALCMP:  st_d.lock_pin = pin_src.osc_cal_comparator;
			`TDL_SEL_FCMP:    st_d.lock_pin = pin_src.freq_comparator;
			default:          st_d.lock_pin = 1'b0;
		endcase
		// Read port; unmapped addresses return zero
		if (cfg_rd_en) begin
			st_d.rd_valid = 1'b1;
			case (cfg_addr)
				`TDL_ADDR_DEV:    st_d.rd_data = st_q.regs.dev & `TDL_MASK_DEV;
				`TDL_ADDR_LOCK:   st_d.rd_data = st_q.regs.lock & `TDL_MASK_LOCK;
				`TDL_ADDR_ANALOG: st_d.rd_data = st_q.regs.analog & `TDL_MASK_ANALOG;
				`TDL_ADDR_SWING:  st_d.rd_data = st_q.regs.swing & `TDL_MASK_SWING;
				default:          st_d.rd_data = 8'h00;
			endcase
		end
	end

	// State register with synchronous reset to documented defaults
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q.regs.dev                  <= `TDL_RST_DEV;
			st_q.regs.lock                 <= `TDL_RST_LOCK;
			st_q.regs.analog               <= `TDL_RST_ANALOG;
			st_q.regs.swing                <= `TDL_RST_SWING;
			st_q.mod.shaping_en            <= 1'b1;
			st_q.mod.ook_en                <= 1'b0;
			st_q.mod.high_band_sel         <= 1'b1;
			st_q.mod.dev_exponent          <= 3'h6;
			st_q.mod.dev_mantissa          <= 4'h8;
			st_q.mod.dev_pow2              <= 5'sh17;
			st_q.bias.phase_det_long_delay <= 1'b0;
			st_q.bias.pa_boost             <= 1'b0;
			st_q.bias.div_buff_current     <= 2'h3;
			st_q.bias.pre_swing            <= 2'h3;
			st_q.bias.tx_swing             <= 3'h1;
			st_q.lock_pin                  <= 1'b0;
			st_q.rd_valid                  <= 1'b0;
			st_q.rd_data                   <= 8'h00;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state register
	assign mod_ctrl     = st_q.mod;
	assign bias_ctrl    = st_q.bias;
	assign lock_pin     = st_q.lock_pin;
	assign cfg_rd_data  = st_q.rd_data;
	assign cfg_rd_valid = st_q.rd_valid;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_dev_write;
		cfg_wr_en && cfg_addr == 7'h0E;
	endsequence

	property p_shaping;
		s_dev_write |=> mod_ctrl.shaping_en == $past(cfg_wr_data[7]);
	endproperty
	a_shaping: assert property (p_shaping) else $error("Shaping enable not taken");

	property p_pow2;
		mod_ctrl.dev_pow2 == $signed({2'b00, mod_ctrl.dev_exponent} -
			(mod_ctrl.high_band_sel ? 5'h0F : 5'h10));
	endproperty
	a_pow2: assert property (p_pow2) else $error("Deviation scale wrong");

	property p_ook;
		s_dev_write ##1 1'b1 |-> mod_ctrl.ook_en == (mod_ctrl.dev_mantissa == 4'h0);
	endproperty
	a_ook: assert property (p_ook) else $error("OOK select wrong");

	property p_pin_steady;
		pin_sel == 4'h2 |=> lock_pin == !$past(lock_ind_steady);
	endproperty
	a_pin_steady: assert property (p_pin_steady) else $error("Lock pin not steady lock");

	property p_pin_low;
		pin_sel == 4'h0 || pin_sel == 4'h4 || pin_sel == 4'h6 ||
			pin_sel == 4'h9 || pin_sel == 4'hA |=> !lock_pin;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("Lock pin not low");

	property p_pin_high;
		pin_sel == 4'h1 |=> lock_pin;
	endproperty
	a_pin_high: assert property (p_pin_high) else $error("Lock pin not high");

	property p_pin_moment;
		pin_sel == 4'h3 |=> lock_pin == !$past(lock_ind_momentary);
	endproperty
	a_pin_moment: assert property (p_pin_moment) else $error("Lock pin not momentary");

	property p_pin_caldone;
		pin_sel == 4'h5 |=> lock_pin == !$past(pin_src.cal_complete);
	endproperty
	a_pin_caldone: assert property (p_pin_caldone) else $error("Lock pin not cal done");

	property p_pin_fcmp;
		pin_sel == 4'hF |=> lock_pin == $past(pin_src.freq_comparator);
	endproperty
	a_pin_fcmp: assert property (p_pin_fcmp) else $error("Lock pin not comparator");

	property p_pin_xosc;
		pin_sel == 4'h7 |=> lock_pin == $past(pin_src.crystal_osc_clk);
	endproperty
	a_pin_xosc: assert property (p_pin_xosc) else $error("Lock pin not oscillator");

	property p_band;
		cfg_wr_en && cfg_addr == 7'h17 |=> mod_ctrl.high_band_sel == $past(cfg_wr_data[7])
			&& bias_ctrl.phase_det_long_delay == $past(cfg_wr_data[4]);
	endproperty
	a_band: assert property (p_band) else $error("Band or delay not taken");

	property p_hold;
		!cfg_wr_en |=> $stable(st_q.regs) && $stable(mod_ctrl) && $stable(bias_ctrl);
	endproperty
	a_hold: assert property (p_hold) else $error("Fields changed without write");

	// A read with no write beside it returns what the modulator is using
	sequence s_dev_read;
		cfg_rd_en && !cfg_wr_en && cfg_addr == 7'h0E;
	endsequence

	property p_rd_valid;
		cfg_rd_en |=> cfg_rd_valid;
	endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("Read answer missing");

	property p_rd_dev;
		s_dev_read |=> cfg_rd_data ==
			{mod_ctrl.shaping_en, mod_ctrl.dev_exponent, mod_ctrl.dev_mantissa};
	endproperty
	a_rd_dev: assert property (p_rd_dev) else $error("Readback differs from levels");

endmodule : tdl_config_regs

// ---- sim/tdl_host_model.sv ----
`timescale 1ns/1ps
`include "tdl_defines.svh"

// Host side of the configuration port; all drives after time zero land on the falling edge
module tdl_host_model (
	// Clock
	input  wire logic                   ref_clk,
	// Register port toward the block
	output logic                        cfg_wr_en,
	output logic                        cfg_rd_en,
	output logic [`TDL_ADDR_W-1:0]      cfg_addr,
	output logic [7:0]                  cfg_wr_data,
	input  wire logic [7:0]             cfg_rd_data,
	input  wire logic                   cfg_rd_valid
);
	// Idle port at time zero
	initial begin
		cfg_wr_en = 1'b0;
		cfg_rd_en = 1'b0;
		cfg_addr = 7'h00;
		cfg_wr_data = 8'h00;
	end

	// Idle address and data flip so stale values never look valid
	task automatic scramble();
		cfg_addr = ~cfg_addr;
		cfg_wr_data = ~cfg_wr_data;
	endtask : scramble

	// One write; the analog spare bit always goes out as zero
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		cfg_addr = a;
		cfg_wr_data = (a == `TDL_ADDR_ANALOG) ? (d & 8'hF7) : d;
		cfg_wr_en = 1'b1;
		@(negedge ref_clk);
		cfg_wr_en = 1'b0;
		scramble();
	endtask : wr

	// One read; data and valid taken in the cycle after the strobe
	task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
		@(negedge ref_clk);
		cfg_addr = a;
		cfg_rd_en = 1'b1;
		@(negedge ref_clk);
		cfg_rd_en = 1'b0;
		d = cfg_rd_data;
		v = cfg_rd_valid;
		scramble();
	endtask : rd
endmodule : tdl_host_model

// ---- sim/tdl_config_regs_bench.sv ----
`timescale 1ns/1ps
`include "tdl_defines.svh"

module tdl_config_regs_bench;
	logic                         ref_clk = 1'b0;  // 40 MHz clock
	logic                         sys_rst = 1'b1;  // Synchronous reset
	logic                         wr_en, rd_en, rd_valid, pd_cmp_valid, lock_pin;
	logic [6:0]                   addr;
	logic [7:0]                   wr_data, rd_data, dv, an, sw, rdv;
	logic [2:0]                   pd_err_cycles;
	logic                         vld;
	tdl_pkg::tdl_pin_src_type     src;
	tdl_pkg::tdl_mod_ctrl_type    mod_ctrl;
	tdl_pkg::tdl_bias_ctrl_type   bias_ctrl;
	int                           err_count = 0, checked = 0, cyc = 0;

	// Clock generator
	always #12.5 ref_clk = ~ref_clk;

	tdl_host_model tdl_host_model_inst (.ref_clk(ref_clk), .cfg_wr_en(wr_en),
		.cfg_rd_en(rd_en), .cfg_addr(addr), .cfg_wr_data(wr_data),
		.cfg_rd_data(rd_data), .cfg_rd_valid(rd_valid));

	tdl_config_regs tdl_config_regs_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.cfg_wr_en(wr_en), .cfg_rd_en(rd_en), .cfg_addr(addr), .cfg_wr_data(wr_data),
		.cfg_rd_data(rd_data), .cfg_rd_valid(rd_valid), .pd_cmp_valid(pd_cmp_valid),
		.pd_err_cycles(pd_err_cycles), .pin_src(src), .mod_ctrl(mod_ctrl),
		.bias_ctrl(bias_ctrl), .lock_pin(lock_pin));

	// Verdict and end of run
	task automatic close_out();
		$display("Counts: checked=%0d err_count=%0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	// Value compare
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Register readback compare
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
		tdl_host_model_inst.rd(a, rdv, vld);
		chk({8'h00, rdv}, {8'h00, exp});
		chk({15'h0, vld}, 16'h0001);
	endtask : rd_chk

	// Control levels against the shadow registers
	task automatic ctl_chk();
		chk({1'b0, mod_ctrl}, {1'b0, dv[7], dv[3:0] == 4'h0, an[7], dv[6:4], dv[3:0],
			5'({2'h0, dv[6:4]}) - (an[7] ? 5'h0F : 5'h10)});
		chk({7'h00, bias_ctrl}, {7'h00, an[4], an[2], an[1:0], sw[7:6], sw[2:0]});
	endtask : ctl_chk

	// Write, let levels settle; the caller updates the shadow
	task automatic wr_sh(input logic [6:0] a, input logic [7:0] d);
		tdl_host_model_inst.wr(a, d);
		repeat (2) @(negedge ref_clk);
	endtask : wr_sh

	// Train of phase comparisons with one error figure
	task automatic cmp(input int n, input logic [2:0] e);
		repeat (n) begin
			@(negedge ref_clk);
			pd_cmp_valid = 1'b1;
			pd_err_cycles = e;
		end
		@(negedge ref_clk);
		pd_cmp_valid = 1'b0;
		repeat (2) @(negedge ref_clk);
	endtask : cmp

	// Expected pin level with both lock indications low
	function automatic logic exp_pin(input logic [3:0] s, input logic [7:0] p);
		case (s)
			4'h1: return 1'b1;
			4'h2, 4'h3: return 1'b1;
			4'h5: return ~p[0];
			4'h7: return p[7];
			4'h8: return p[6];
			4'hB: return p[5];
			4'hC: return p[4];
			4'hD: return p[3];
			4'hE: return p[2];
			4'hF: return p[1];
			default: return 1'b0;
		endcase
	endfunction : exp_pin

	// Hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 4000) begin
			err_count++;
			close_out();
		end
	end

	// Main sequence
	initial begin
		pd_cmp_valid = 1'b0;
		pd_err_cycles = 3'h0;
		src = 8'h00;
		dv = 8'hE8;
		an = 8'h83;
		sw = 8'hC1;
		repeat (4) @(negedge ref_clk);
		sys_rst = 1'b0;
		// Reset values and readback
		rd_chk(`TDL_ADDR_DEV, 8'hE8);
		rd_chk(`TDL_ADDR_LOCK, 8'h00);
		rd_chk(`TDL_ADDR_ANALOG, 8'h83);
		rd_chk(`TDL_ADDR_SWING, 8'hC1);
		rd_chk(7'h00, 8'h00);
		ctl_chk();
		$display("Test reset values done");
		// Field decode after writes
		dv = 8'h4C;
		wr_sh(`TDL_ADDR_DEV, dv);
		ctl_chk();
		dv = 8'h30;
		wr_sh(`TDL_ADDR_DEV, dv);
		ctl_chk();
		an = 8'h17;
		wr_sh(`TDL_ADDR_ANALOG, 8'h1F);
		ctl_chk();
		rd_chk(`TDL_ADDR_ANALOG, 8'h17);
		sw = 8'h3A;
		wr_sh(`TDL_ADDR_SWING, sw);
		ctl_chk();
		rd_chk(`TDL_ADDR_SWING, 8'h02);
		wr_sh(7'h01, 8'hFF);
		rd_chk(`TDL_ADDR_DEV, 8'h30);
		ctl_chk();
		$display("Test field decode done");
		// Every selector code with two source patterns
		for (int c = 0; c < 16; c++) begin
			wr_sh(`TDL_ADDR_LOCK, {4'(c), 4'h0});
			src = 8'hA5;
			repeat (2) @(negedge ref_clk);
			chk({15'h0, lock_pin}, {15'h0, exp_pin(4'(c), 8'hA5)});
			src = 8'h5A;
			repeat (2) @(negedge ref_clk);
			chk({15'h0, lock_pin}, {15'h0, exp_pin(4'(c), 8'h5A)});
		end
		$display("Test lock pin select done");
		// Lock detector through the pin
		wr_sh(`TDL_ADDR_LOCK, 8'h20);
		cmp(126, 3'h1);
		chk({15'h0, lock_pin}, 16'h0001);
		cmp(1, 3'h1);
		chk({15'h0, lock_pin}, 16'h0000);
		wr_sh(`TDL_ADDR_LOCK, 8'h30);
		chk({15'h0, lock_pin}, 16'h0000);
		cmp(1, 3'h2);
		chk({15'h0, lock_pin}, 16'h0001);
		wr_sh(`TDL_ADDR_LOCK, 8'h20);
		chk({15'h0, lock_pin}, 16'h0001);
		wr_sh(`TDL_ADDR_LOCK, 8'h28);
		cmp(127, 3'h3);
		chk({15'h0, lock_pin}, 16'h0000);
		wr_sh(`TDL_ADDR_LOCK, 8'h2C);
		cmp(1, 3'h4);
		chk({15'h0, lock_pin}, 16'h0000);
		// Accuracy codes 1 to 3, with up/down hysteresis on code 1
		wr_sh(`TDL_ADDR_LOCK, 8'h21);
		cmp(1, 3'h7);
		chk({15'h0, lock_pin}, 16'h0001);
		cmp(254, 3'h1);
		chk({15'h0, lock_pin}, 16'h0001);
		cmp(1, 3'h1);
		chk({15'h0, lock_pin}, 16'h0000);
		wr_sh(`TDL_ADDR_LOCK, 8'h25);
		cmp(15, 3'h7);
		chk({15'h0, lock_pin}, 16'h0000);
		cmp(1, 3'h7);
		chk({15'h0, lock_pin}, 16'h0001);
		wr_sh(`TDL_ADDR_LOCK, 8'h22);
		cmp(271, 3'h1);
		chk({15'h0, lock_pin}, 16'h0001);
		cmp(1, 3'h1);
		chk({15'h0, lock_pin}, 16'h0000);
		wr_sh(`TDL_ADDR_LOCK, 8'h23);
		cmp(511, 3'h1);
		chk({15'h0, lock_pin}, 16'h0001);
		cmp(1, 3'h1);
		chk({15'h0, lock_pin}, 16'h0000);
		$display("Test lock detector done");
		close_out();
	end
endmodule : tdl_config_regs_bench
